// >>> src/payload_fifo_pkg.sv
// package: register map, fields, command codes and limits of the payload fifo block
`default_nettype none
package payload_fifo_pkg;
   // ==========================================================
   // register offsets (5-bit register address space)
   localparam logic [4:0] pipe1_rx_width_addr = 5'h12;
   localparam logic [4:0] pipe2_rx_width_addr = 5'h13;
   localparam logic [4:0] pipe3_rx_width_addr = 5'h14;
   localparam logic [4:0] pipe4_rx_width_addr = 5'h15;
   localparam logic [4:0] pipe5_rx_width_addr = 5'h16;
   localparam logic [4:0] payload_fifo_flags_addr = 5'h17;
   // ==========================================================
   // field positions and reset values
   localparam int width_msb = 5;
   localparam logic [5:0] max_payload_bytes = 6'h20;
   localparam int flag_reuse_bit = 6;
   localparam int flag_tx_full_bit = 5;
   localparam int flag_tx_empty_bit = 4;
   localparam int flag_rx_full_bit = 1;
   localparam int flag_rx_empty_bit = 0;
   localparam logic [7:0] width_reset = 8'h00;
   localparam logic [7:0] flags_reset = 8'h11;
   // ==========================================================
   // payload commands
   localparam logic [2:0] cmd_width = 3'h3;
   typedef enum logic [2:0] {
      cmd_none = 3'h0,
      cmd_write_tx = 3'h1,
      cmd_write_ack = 3'h2,
      cmd_reuse = 3'h3,
      cmd_flush_tx = 3'h4,
      cmd_flush_rx = 3'h5,
      cmd_read_rx = 3'h6
   } payload_cmd_t;
   // ==========================================================
   // depths and timing
   localparam int fifo_depth = 3;
   localparam int reuse_ce_ns = 10000;
   localparam int clk_period_ns = 50;
   localparam int reuse_ce_cycles =
      (reuse_ce_ns + clk_period_ns - 1) / clk_period_ns;
endpackage
`default_nettype wire

// >>> src/payload_slot_fifo.sv
// small payload fifo: slot storage with push, pop, flush and honest flags
`default_nettype none
module payload_slot_fifo
   import payload_fifo_pkg::*;
#(
   parameter int data_w = 256,
   parameter int tag_w = 3,
   parameter int depth = 3
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic push,
   input wire logic [data_w-1:0] push_data,
   input wire logic [tag_w-1:0] push_tag,
   input wire logic pop,
   input wire logic flush,
   output logic [data_w-1:0] head_data,
   output logic [tag_w-1:0] head_tag,
   output logic full,
   output logic empty
);
   localparam int ptr_w = $clog2(depth);
   logic [data_w-1:0] slot_data [depth];
   logic [tag_w-1:0] slot_tag [depth];
   logic [ptr_w-1:0] wr_ptr, rd_ptr;
   logic [ptr_w:0] count;
   wire do_push = push && (count != depth[ptr_w:0]);
   wire do_pop = pop && (count != '0);

   function automatic logic [ptr_w-1:0] bump(input logic [ptr_w-1:0] p);
      bump = (p == ptr_w'(depth - 1)) ? '0 : ptr_w'(p + 1'b1);
   endfunction

   // ==========================================================
   // storage
   always_ff @(posedge mclk) begin
      if (do_push) begin
         slot_data[wr_ptr] <= push_data;
         slot_tag[wr_ptr] <= push_tag;
      end
   end

   // ==========================================================
   // pointers; flush wins over a push in the same cycle
   always_ff @(posedge mclk) begin
      if (srst || flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) wr_ptr <= bump(wr_ptr);
         if (do_pop) rd_ptr <= bump(rd_ptr);
         if (do_push && !do_pop) count <= count + 1'b1;
         else if (do_pop && !do_push) count <= count - 1'b1;
      end
   end

   assign head_data = slot_data[rd_ptr];
   assign head_tag = slot_tag[rd_ptr];
   assign full = (count == depth[ptr_w:0]);
   assign empty = (count == '0);
endmodule
`default_nettype wire

// >>> src/reuse_ce_timer.sv
// counts how long chip enable is held high while payload reuse is active
`default_nettype none
module reuse_ce_timer
   import payload_fifo_pkg::*;
#(
   parameter int hold_cycles = reuse_ce_cycles
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic armed,
   input wire logic ce_level,
   output logic fire
);
   localparam int cnt_w = $clog2(hold_cycles + 1);
   logic [cnt_w-1:0] count;
   logic done;
   // one pulse per stretch with both armed and chip enable high, once the hold time is met
   always_ff @(posedge mclk) begin
      if (srst || !armed || !ce_level) begin
         count <= '0;
         done <= 1'b0;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (!done && count == cnt_w'(hold_cycles - 1)) begin
            done <= 1'b1;
            fire <= 1'b1;
         end else if (!done) begin
            count <= count + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> src/radio_payload_fifo_status.sv
// payload width registers, fifo status and payload queues of the radio
// ============================================================
// Notes on behaviour
// - pipes one to five hold six-bit widths
// - reuse command sets reuse status bit six
// - tx full bit five, empty bit four
// - rx full bit one, empty bit zero
// - ack payloads via pipe-tagged command, receiver only
// - at most three ack payloads pending
// - same-pipe ack payloads leave in order
// - tx payloads by command only, unreadable
// - tx fifo three deep, transmitter only
// - ack payloads need feature enable bit
// - all pipes share one three-level rx fifo
`default_nettype none
module radio_payload_fifo_status
   import payload_fifo_pkg::*;
#(
   parameter int payload_w = 256,
   parameter int depth = fifo_depth,
   parameter int reuse_hold_cycles = reuse_ce_cycles
) (
   input wire logic mclk,
   input wire logic srst,
   // register port from the command decoder
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // payload command port
   input wire logic cmd_valid,
   input wire logic [cmd_width-1:0] cmd_code,
   input wire logic [2:0] target_pipe_number,
   input wire logic [payload_w-1:0] cmd_payload,
   input wire logic [5:0] cmd_length,
   output logic cmd_refused,
   output logic [payload_w-1:0] receive_payload_queue,
   output logic [2:0] rx_pipe_out,
   output logic rx_payload_valid,
   // radio side
   input wire logic primary_transmitter_role,
   input wire logic ack_payload_enable,
   input wire logic chip_enable,
   input wire logic tx_take,
   input wire logic ack_take,
   input wire logic rx_store,
   input wire logic [2:0] rx_store_pipe,
   input wire logic [payload_w-1:0] rx_store_data,
   output logic [payload_w-1:0] tx_head,
   output logic tx_head_valid,
   output logic tx_resend,
   output logic [payload_w-1:0] ack_head,
   output logic [2:0] ack_head_pipe,
   output logic ack_head_valid
);
   // ==========================================================
   // chip enable pin synchroniser
   logic ce_s1, ce_s2, ce_s3, ce_level;
   always_ff @(posedge mclk) begin
      ce_s1 <= chip_enable;
      ce_s2 <= ce_s1;
      ce_s3 <= ce_s2;
   end
   always_ff @(posedge mclk) begin
      if (srst) ce_level <= 1'b0;
      else if (ce_s2 == ce_s3) ce_level <= ce_s3;
   end

   // ==========================================================
   // command decode
   wire length_ok = (cmd_length != 6'h00) &&
      (cmd_length <= max_payload_bytes);
   wire is_tx_wr = cmd_valid && cmd_code == cmd_write_tx;
   wire is_ack_wr = cmd_valid && cmd_code == cmd_write_ack;
   wire is_reuse = cmd_valid && cmd_code == cmd_reuse;
   wire is_flush_tx = cmd_valid && cmd_code == cmd_flush_tx;
   wire is_flush_rx = cmd_valid && cmd_code == cmd_flush_rx;
   wire is_read_rx = cmd_valid && cmd_code == cmd_read_rx;
   wire pipe_ok = target_pipe_number <= 3'h5;
   wire tx_full, tx_empty, ack_full, ack_empty, rx_full, rx_empty;
   // declared here because the tx pop gate below already reads it
   logic reuse_active;
   // tx queue only in transmitter role, length one to 32 bytes
   wire tx_push = is_tx_wr && primary_transmitter_role &&
      length_ok && !tx_full;
   // ack queue: receiver role, feature enabled, pipe tagged
   wire ack_push = is_ack_wr && !primary_transmitter_role &&
      ack_payload_enable && pipe_ok && length_ok &&
      !ack_full;
   wire rx_pop = is_read_rx && !rx_empty;
   wire accepted = tx_push || ack_push || is_reuse || is_flush_tx ||
      is_flush_rx || rx_pop;
   wire tx_pop = tx_take && primary_transmitter_role && !reuse_active;
   wire ack_pop = ack_take && !primary_transmitter_role;

   // ==========================================================
   // payload queues
   logic [payload_w-1:0] tx_head_q;
   logic [payload_w-1:0] ack_head_q;
   logic [payload_w-1:0] rx_head_data;
   logic [2:0] rx_head_pipe;
   logic [2:0] ack_tag;

   payload_slot_fifo #(.data_w(payload_w), .tag_w(1), .depth(depth))
   tx_q (
      .mclk(mclk),
      .srst(srst),
      .push(tx_push),
      .push_data(cmd_payload),
      .push_tag(1'b0),
      .pop(tx_pop),
      .flush(is_flush_tx),
      .head_data(tx_head_q),
      .head_tag(),
      .full(tx_full),
      .empty(tx_empty)
   );

   // one queue in arrival order keeps same-pipe payloads ordered
   payload_slot_fifo #(.data_w(payload_w), .tag_w(3), .depth(depth))
   ack_q (
      .mclk(mclk),
      .srst(srst),
      .push(ack_push),
      .push_data(cmd_payload),
      .push_tag(target_pipe_number),
      .pop(ack_pop),
      .flush(1'b0),
      .head_data(ack_head_q),
      .head_tag(ack_tag),
      .full(ack_full),
      .empty(ack_empty)
   );

   payload_slot_fifo #(.data_w(payload_w), .tag_w(3), .depth(depth))
   rx_q (
      .mclk(mclk),
      .srst(srst),
      .push(rx_store),
      .push_data(rx_store_data),
      .push_tag(rx_store_pipe),
      .pop(rx_pop),
      .flush(is_flush_rx),
      .head_data(rx_head_data),
      .head_tag(rx_head_pipe),
      .full(rx_full),
      .empty(rx_empty)
   );

   // ==========================================================
   // queue heads, registered so every output leaves a flip-flop
   // the radio sees a new head one cycle after the fifo moves; a take
   // against a stale valid is harmless because each fifo gates its
   // own pop on its occupancy count
   // empty queues show zero rather than whatever a slot last held
   always_ff @(posedge mclk) begin
      if (srst) begin
         tx_head <= '0;
         tx_head_valid <= 1'b0;
         ack_head <= '0;
         ack_head_pipe <= 3'h0;
         ack_head_valid <= 1'b0;
      end else begin
         tx_head <= tx_empty ? '0 : tx_head_q;
         tx_head_valid <= !tx_empty;
         ack_head <= ack_empty ? '0 : ack_head_q;
         ack_head_pipe <= ack_empty ? 3'h0 : ack_tag;
         ack_head_valid <= !ack_empty;
      end
   end

   // ==========================================================
   // payload reuse
   logic next_reuse;
   // set wins when reuse and a clearing command could coincide;
   // only one command per cycle, so they never do
   assign next_reuse = is_reuse ? 1'b1 :
      (tx_push || is_flush_tx) ? 1'b0 : reuse_active;
   always_ff @(posedge mclk) begin
      if (srst) reuse_active <= 1'b0;
      else reuse_active <= next_reuse;
   end

   // resend only after chip enable was held for the full time
   reuse_ce_timer #(.hold_cycles(reuse_hold_cycles)) ce_timer (
      .mclk(mclk),
      .srst(srst),
      .armed(reuse_active && primary_transmitter_role && !tx_empty),
      .ce_level(ce_level),
      .fire(tx_resend)
   );

   // ==========================================================
   // width registers, pipes one to five
   logic [5:0] pipe_width [5];
   wire [2:0] wr_idx = 3'(reg_addr - pipe1_rx_width_addr);
   wire width_hit = reg_addr >= pipe1_rx_width_addr &&
      reg_addr <= pipe5_rx_width_addr;
   always_ff @(posedge mclk) begin
      if (srst) begin
         for (int i = 0; i < 5; i++) pipe_width[i] <= width_reset[5:0];
      end else if (reg_wr && width_hit) begin
         // reserved bits 7:6 are not stored and read back as zero
         pipe_width[wr_idx] <= reg_wdata[width_msb:0];
      end
   end

   // ==========================================================
   // status flags, registered one cycle after the fifo changes
   logic [7:0] fifo_flags;
   wire [7:0] next_flags = {1'b0, reuse_active, tx_full, tx_empty,
      2'b00, rx_full, rx_empty};
   always_ff @(posedge mclk) begin
      if (srst) fifo_flags <= flags_reset;
      else fifo_flags <= next_flags;
   end

   // ==========================================================
   // register read; payload queues are not in the register map
   wire [7:0] width_rd = {2'b00, pipe_width[wr_idx]};
   wire [7:0] rd_mux = width_hit ? width_rd :
      (reg_addr == payload_fifo_flags_addr) ? fifo_flags :
      8'h00;
   always_ff @(posedge mclk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) reg_rdata <= rd_mux;
      end
   end

   // ==========================================================
   // command answers and receive payload output
   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd_refused <= 1'b0;
         rx_payload_valid <= 1'b0;
         receive_payload_queue <= '0;
         rx_pipe_out <= 3'h7;
      end else begin
         cmd_refused <= cmd_valid && !accepted;
         rx_payload_valid <= rx_pop;
         if (rx_pop) begin
            receive_payload_queue <= rx_head_data;
            rx_pipe_out <= rx_head_pipe;
         end
      end
   end
endmodule
`default_nettype wire

// >>> testbench/payload_fifo_props.sv
// checker: port-level properties of the payload fifo status block
`default_nettype none
module payload_fifo_props import payload_fifo_pkg::*; (
   input wire logic mclk,
   input wire logic srst,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire logic cmd_valid,
   input wire logic [cmd_width-1:0] cmd_code,
   input wire logic [5:0] cmd_length,
   input wire logic cmd_refused,
   input wire logic primary_transmitter_role,
   input wire logic ack_payload_enable,
   input wire logic chip_enable,
   input wire logic tx_resend,
   input wire logic rx_payload_valid,
   input wire logic [2:0] rx_pipe_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // ====
   // helper terms
   logic [3:0] ce_low;
   wire logic tx_wr = cmd_valid && cmd_code == cmd_write_tx;
   wire logic ack_wr = cmd_valid && cmd_code == cmd_write_ack;
   // cycles since chip enable was seen high; covers the synchroniser lag
   always_ff @(posedge mclk)
      ce_low <= (srst || chip_enable) ? 4'h0 :
         ce_low + {3'h0, ce_low != 4'hF};
   // ====
   // properties
   AST_WIDTH_RSVD:
   assert property (reg_rd && reg_addr inside {[5'h12:5'h16]}
      |=> reg_rdata[7:6] == 2'h0) else $error("width bits 7:6 set");
   AST_FLAG_RSVD:
   assert property (reg_rd && reg_addr == payload_fifo_flags_addr
      |=> !reg_rdata[7] && reg_rdata[3:2] == 2'h0) else $error("flag rsvd");
   AST_TX_ROLE:
   assert property (tx_wr && !primary_transmitter_role |=> cmd_refused)
      else $error("tx write as receiver taken");
   AST_TX_LEN:
   assert property (tx_wr && (cmd_length == 6'h00 ||
      cmd_length > max_payload_bytes) |=> cmd_refused)
      else $error("bad tx length taken");
   AST_ACK_ROLE:
   assert property (ack_wr && primary_transmitter_role |=> cmd_refused)
      else $error("ack write as transmitter taken");
   AST_ACK_FEAT:
   assert property (ack_wr && !ack_payload_enable |=> cmd_refused)
      else $error("ack write with feature off taken");
   AST_REUSE_OK:
   assert property (cmd_valid && cmd_code == cmd_reuse |=> !cmd_refused)
      else $error("reuse refused");
   AST_RX_PIPE:
   assert property (rx_payload_valid |-> rx_pipe_out <= 3'h5)
      else $error("rx pipe out of range");
   AST_RESEND_CE:
   assert property (tx_resend |-> ce_low < 4'h6)
      else $error("resend without chip enable");
endmodule
bind radio_payload_fifo_status payload_fifo_props u_props (
   .mclk(mclk), .srst(srst), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_length(cmd_length), .cmd_refused(cmd_refused),
   .primary_transmitter_role(primary_transmitter_role),
   .ack_payload_enable(ack_payload_enable), .chip_enable(chip_enable),
   .tx_resend(tx_resend), .rx_payload_valid(rx_payload_valid),
   .rx_pipe_out(rx_pipe_out));
`default_nettype wire

// >>> testbench/host_model.sv
// host model: the microcontroller issuing register and payload commands
`default_nettype none
module host_model import payload_fifo_pkg::*; (
   input wire logic mclk,
   input wire logic [7:0] reg_rdata,
   input wire logic cmd_refused,
   output logic reg_wr,
   output logic reg_rd,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic [2:0] target_pipe_number,
   output logic [255:0] cmd_payload,
   output logic [5:0] cmd_length,
   output logic chip_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata, cmd_valid, cmd_code,
      target_pipe_number, cmd_payload, cmd_length, chip_enable} = '0;
   // ====
   // register access; released data lines flip so stale values never match
   task automatic acc(input logic w, input logic [4:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wdata <= ~d;
      #1 q = reg_rdata;
   endtask
   task automatic cmd(input logic [2:0] c, input logic [2:0] p,
      input logic [5:0] n, input logic [255:0] d, output logic r);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      target_pipe_number <= p;
      cmd_length <= n;
      cmd_payload <= d;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_payload <= ~d;
      #1 r = cmd_refused;
   endtask
   task automatic ce(input int n);
      @(posedge mclk);
      chip_enable <= 1'b1;
      repeat (n) @(posedge mclk);
      chip_enable <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// testbench: queue model of the payload fifos compared with the design
`default_nettype none
module testbench import payload_fifo_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int hold = 4;
   logic mclk = 1'b0, srst = 1'b1, role = 1'b1, ack_en = 1'b0;
   logic tx_take = 1'b0, ack_take = 1'b0, rx_store = 1'b0, reuse = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, cmd_valid, cmd_refused, rx_valid, r;
   logic chip_enable, tx_resend, tx_hv, ack_hv;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, q, w;
   logic [2:0] cmd_code, pipe, rx_pipe, ack_pipe, st_pipe = 3'h0;
   logic [5:0] cmd_length;
   logic [255:0] cmd_payload, rx_data, tx_head, ack_head, st_data = '0;
   logic [255:0] txq[$];
   logic [258:0] ackq[$], rxq[$];
   int seed = 41315, err_count = 0, compares = 0, resends = 0;
   always #25 mclk = ~mclk;
   always @(posedge mclk) resends <= resends + tx_resend;
   host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .cmd_refused(cmd_refused), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .target_pipe_number(pipe), .cmd_payload(cmd_payload),
      .cmd_length(cmd_length), .chip_enable(chip_enable));
   radio_payload_fifo_status #(.reuse_hold_cycles(hold)) u_dut (
      .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .target_pipe_number(pipe), .cmd_payload(cmd_payload),
      .cmd_length(cmd_length), .cmd_refused(cmd_refused),
      .receive_payload_queue(rx_data), .rx_pipe_out(rx_pipe),
      .rx_payload_valid(rx_valid), .primary_transmitter_role(role),
      .ack_payload_enable(ack_en), .chip_enable(chip_enable),
      .tx_take(tx_take), .ack_take(ack_take), .rx_store(rx_store),
      .rx_store_pipe(st_pipe), .rx_store_data(st_data), .tx_head(tx_head),
      .tx_head_valid(tx_hv), .tx_resend(tx_resend), .ack_head(ack_head),
      .ack_head_pipe(ack_pipe), .ack_head_valid(ack_hv));
   // ====
   // checking helpers
   task automatic chk(input logic [259:0] got, exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic look();
      u_host.acc(1'b0, payload_fifo_flags_addr, 8'h00, q);
      chk({reg_rvalid, q}, {1'b1, 1'b0, reuse, txq.size() == fifo_depth,
         txq.size() == 0, 2'h0, rxq.size() == fifo_depth,
         rxq.size() == 0});
      chk({tx_hv, ack_hv}, {txq.size() > 0, ackq.size() > 0});
      if (txq.size() > 0) chk(tx_head, txq[0]);
      if (ackq.size() > 0) chk({ack_pipe, ack_head}, ackq[0]);
   endtask
   task automatic op(input payload_cmd_t c, input logic [2:0] p,
      input logic [5:0] n, input logic [255:0] d);
      logic bad, e;
      u_host.cmd(c, p, n, d, r);
      bad = n == 6'h00 || n > 6'h20;
      e = (c == cmd_read_rx) && rxq.size() == 0;
      if (c == cmd_write_tx) e = !role || txq.size() == fifo_depth || bad;
      if (c == cmd_write_ack)
         e = role || !ack_en || p > 3'h5 || ackq.size() == fifo_depth || bad;
      chk(r, e);
      if (!e && c == cmd_write_tx) txq.push_back(d);
      if (!e && c == cmd_write_ack) ackq.push_back({p, d});
      if (c == cmd_reuse) reuse = 1'b1;
      if (c == cmd_flush_tx || (!e && c == cmd_write_tx)) reuse = 1'b0;
      if (c == cmd_flush_tx) txq.delete();
      if (c == cmd_flush_rx) rxq.delete();
      if (!e && c == cmd_read_rx)
         chk({rx_valid, rx_pipe, rx_data}, {1'b1, rxq.pop_front()});
      look();
   endtask
   task automatic radio(input logic t, a, s, input logic [2:0] p);
      @(posedge mclk);
      tx_take <= t;
      ack_take <= a;
      rx_store <= s;
      st_pipe <= p;
      st_data <= {8{$random(seed)}};
      @(posedge mclk);
      tx_take <= 1'b0;
      ack_take <= 1'b0;
      rx_store <= 1'b0;
      st_data <= ~st_data;
      if (t && !reuse && txq.size() > 0) void'(txq.pop_front());
      if (a && ackq.size() > 0) void'(ackq.pop_front());
      if (s) rxq.push_back({p, st_data});
      look();
   endtask
   task automatic wrap_up();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ====
   // scenarios
   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      for (int a = 17; a < 24; a++) begin
         u_host.acc(1'b0, a[4:0], 8'h00, q);
         chk(q, (a == 23) ? flags_reset : width_reset);
      end
      for (int a = 5; a < 23; a += (a == 5) ? 13 : 1) begin
         w = $random(seed);
         u_host.acc(1'b1, a[4:0], w, q);
         u_host.acc(1'b0, a[4:0], 8'h00, q);
         chk(q, (a == 5) ? 8'h00 : {2'h0, w[5:0]});
      end
      op(cmd_write_ack, 3'h1, 6'h20, '1);
      op(cmd_write_tx, 3'h0, 6'h00, '1);
      op(cmd_write_tx, 3'h0, 6'h21, '1);
      repeat (4) op(cmd_write_tx, 3'h0, 6'h20, {8{$random(seed)}});
      radio(1'b1, 1'b0, 1'b0, 3'h0);
      op(cmd_reuse, 3'h0, 6'h00, '0);
      radio(1'b1, 1'b0, 1'b0, 3'h0);
      u_host.ce(1);
      u_host.ce(hold + 6);
      repeat (8) @(posedge mclk);
      chk(resends, 1);
      op(cmd_write_tx, 3'h0, 6'h20, {8{$random(seed)}});
      op(cmd_reuse, 3'h0, 6'h00, '0);
      op(cmd_flush_tx, 3'h0, 6'h00, '0);
      @(posedge mclk);
      role <= 1'b0;
      op(cmd_write_tx, 3'h0, 6'h20, '1);
      op(cmd_write_ack, 3'h2, 6'h20, '1);
      @(posedge mclk);
      ack_en <= 1'b1;
      op(cmd_write_ack, 3'h6, 6'h20, '1);
      for (int i = 0; i < 4; i++)
         op(cmd_write_ack, 3'(2 + i % 2), 6'h20, {8{$random(seed)}});
      repeat (3) radio(1'b0, 1'b1, 1'b0, 3'h0);
      op(cmd_read_rx, 3'h0, 6'h00, '0);
      for (int i = 0; i < 3; i++) radio(1'b0, 1'b0, 1'b1, 3'(2 * i + 1));
      repeat (2) op(cmd_read_rx, 3'h0, 6'h00, '0);
      op(cmd_flush_rx, 3'h0, 6'h00, '0);
      op(cmd_read_rx, 3'h0, 6'h00, '0);
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      wrap_up();
   end
endmodule
`default_nettype wire
